// >>> hdl/ccbs_top.sv
// Purpose: bus status signalling, interrupt request capture, bus release
//   and condition testing, with an apb register file for software
// Assumes: single 50 MHz pclk; pins synchronised before use
// Notes: software starts machine cycles through the cycle register
`timescale 1ns/100ps
`include "ccbs_defs.svh"
// How it works
// - codes 0000 never, 1000 always, plain flag tests
// - codes 1110,1111,1101,1100 test cleared flags
// - 1001/0001 test sign xor overflow
// - 1010/0010 add zero to that test
// - 1011/0011 unsigned carry and zero tests
// - status 0000..0011 internal, refresh, io
// - status 0100..0111 acknowledge cycle kinds
// - status 1000..1011 data and stack accesses
// - status 1101,1100 fetch; 1110 ext transfer; 1111 never
// - address strobe rises with valid address
// - byte high, write low, system low
// - memory request low only for memory
// - grant low once bus released
// - falling edge raises top-priority request
// - low level on irq inputs pends
// - wait low stalls the transfer
// - seven-bit segment number output
// - test-chain sets sign when input low
// - machine cycle three to ten clocks
// - block io 21 clocks, repeat 11+10n
// - privileged ops only in system mode
// - wait sampled in t2, repeats each tw
module ccbs_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // bus status pins
  output logic [3:0] cycle_kind,
  output logic [6:0] seg_num,
  output logic [15:0] addr_data_out,
  output logic addr_data_oe_n,
  input wire logic [15:0] addr_data_in,
  output logic addr_strobe_n,
  output logic xfer_strobe_n,
  output logic mem_access_n,
  output logic byte_sel,
  output logic read_sel,
  output logic normal_mode,
  output logic ctl_oe_n,
  // control pins
  input wire logic wait_n,
  input wire logic bus_claim_n,
  output logic bus_grant_n,
  input wire logic nmi_n,
  input wire logic plain_irq_n,
  input wire logic vect_irq_n,
  input wire logic seg_fault_n,
  input wire logic test_chain_in,
  output logic chain_out_n
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [6:0] pins_s;
  logic wait_s, claim_s, nmi_s, pirq_s, virq_s, segf_s, chain_s;
  ccbs_sync #(.W(7), .INIT(7'h7f)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({wait_n, bus_claim_n, nmi_n, plain_irq_n, vect_irq_n, seg_fault_n,
      test_chain_in}),
    .dout(pins_s)
  );
  assign {wait_s, claim_s, nmi_s, pirq_s, virq_s, segf_s, chain_s} = pins_s;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // ctrl: [0] system mode, [1] plain irq enable, [2] vect irq enable,
  //   [3] chain out request, [4] segmented variant
  logic [4:0] ctrl_q, ctrl_d;
  logic [3:0] flags_q, flags_d; // c z s pv in bits 3..0
  logic [3:0] cond_q, cond_d;
  logic [3:0] kind_q, kind_d;
  logic [15:0] addr_q, addr_d;
  logic [6:0] seg_q, seg_d;
  logic byte_q, byte_d, rd_q, rd_d, priv_q, priv_d;
  logic [3:0] xlen_q, xlen_d; // extra internal clocks
  logic nmi_pend_q, nmi_pend_d, nmi_prev_q, nmi_prev_d;
  logic trap_q, trap_d;
  logic [15:0] rdata_q, rdata_d;
  logic [15:0] count_q, count_d;
  logic rep_q, rep_d;
  logic [7:0] blk_left_q, blk_left_d;
  logic [15:0] blk_clks_q, blk_clks_d;
  ccbs_pkg::ccbs_blk_t blk_q, blk_d;
  ccbs_pkg::ccbs_state_t st_q, st_d;
  logic [3:0] clk_cnt_q, clk_cnt_d;
  logic cond_true;
  logic wr_acc, rd_acc, start;

  ccbs_cond_eval u_cond (
    .cond(cond_q),
    .flag_c(flags_q[3]),
    .flag_z(flags_q[2]),
    .flag_s(flags_q[1]),
    .flag_pv(flags_q[0]),
    .cond_true(cond_true)
  );

  // ----------------------------------------------------------------
  // apb
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign pslverr = 1'b0;
  // new cycle only from idle; writes while busy are dropped
  assign start = wr_acc && paddr == `CCBS_OFF_CYCLE && st_q == ccbs_pkg::CCBS_IDLE;

  always_comb begin
    prdata = 32'h0;
    if (rd_acc) begin
      case (paddr)
        `CCBS_OFF_CTRL: prdata = {27'h0, ctrl_q};
        `CCBS_OFF_FLAGS: prdata = {23'h0, cond_true, cond_q, flags_q};
        `CCBS_OFF_CYCLE: prdata = {16'h0, addr_q};
        `CCBS_OFF_STATUS: prdata = {16'h0, rdata_q};
        `CCBS_OFF_BLOCK: prdata = {blk_clks_q, count_q};
        `CCBS_OFF_SEG: prdata = {22'h0, trap_q, nmi_pend_q, !pirq_s, !virq_s,
          !segf_s, !bus_grant_n, st_q, seg_q[0]};
        default: prdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // machine cycle sequencer
  // ----------------------------------------------------------------
  logic is_io, is_mem, is_priv_kind;
  always_comb begin
    is_io = kind_q == `CCBS_ST_IO || kind_q == `CCBS_ST_SPECIAL_IO;
    is_mem = kind_q[3] && kind_q != `CCBS_ST_EXT_XFER;
    is_priv_kind = is_io;
  end

  always_comb begin
    st_d = st_q;
    clk_cnt_d = clk_cnt_q;
    kind_d = kind_q;
    addr_d = addr_q;
    byte_d = byte_q;
    rd_d = rd_q;
    priv_d = priv_q;
    xlen_d = xlen_q;
    rdata_d = rdata_q;
    trap_d = trap_q;
    case (st_q)
      ccbs_pkg::CCBS_IDLE: begin
        if (!claim_s) begin
          st_d = ccbs_pkg::CCBS_RELEASED;
        end else if (start) begin
          kind_d = pwdata[19:16] == `CCBS_ST_RESERVED ? `CCBS_ST_INTERNAL
            : pwdata[19:16];
          addr_d = pwdata[15:0];
          byte_d = pwdata[20];
          rd_d = pwdata[21];
          priv_d = pwdata[22];
          xlen_d = pwdata[26:23] > 4'd5 ? 4'd5 : pwdata[26:23];
          if ((pwdata[22] || pwdata[19:17] == 3'b001) && !ctrl_q[0]) begin
            trap_d = 1'b1;
          end else begin
            trap_d = 1'b0;
            st_d = ccbs_pkg::CCBS_T1;
          end
        end
      end
      ccbs_pkg::CCBS_T1: st_d = ccbs_pkg::CCBS_T2;
      ccbs_pkg::CCBS_T2: begin
        clk_cnt_d = 4'd0;
        if (kind_q == `CCBS_ST_INTERNAL || kind_q == `CCBS_ST_REFRESH) begin
          st_d = xlen_q != 4'd0 ? ccbs_pkg::CCBS_TX : ccbs_pkg::CCBS_T3;
        end else if (!wait_s || is_io) begin
          st_d = ccbs_pkg::CCBS_TW;
        end else begin
          st_d = ccbs_pkg::CCBS_T3;
        end
      end
      ccbs_pkg::CCBS_TW: begin
        clk_cnt_d = clk_cnt_q + 4'd1;
        // keep stretching while wait is low, within ten clocks total
        if (wait_s || clk_cnt_q == `CCBS_CYC_MAX_CLKS - 4'd4) begin
          st_d = ccbs_pkg::CCBS_T3;
        end
      end
      ccbs_pkg::CCBS_TX: begin
        clk_cnt_d = clk_cnt_q + 4'd1;
        if (clk_cnt_q + 4'd1 == xlen_q) begin
          st_d = ccbs_pkg::CCBS_T3;
        end
      end
      ccbs_pkg::CCBS_T3: begin
        if (rd_q) begin
          rdata_d = addr_data_in;
        end
        st_d = ccbs_pkg::CCBS_IDLE;
      end
      ccbs_pkg::CCBS_RELEASED: begin
        if (claim_s) begin
          st_d = ccbs_pkg::CCBS_IDLE;
        end
      end
      default: st_d = ccbs_pkg::CCBS_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // control, flags, interrupts
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    flags_d = flags_q;
    cond_d = cond_q;
    seg_d = seg_q;
    nmi_prev_d = nmi_s;
    nmi_pend_d = nmi_pend_q;
    if (nmi_prev_q && !nmi_s) begin
      nmi_pend_d = 1'b1;
    end else if (st_q == ccbs_pkg::CCBS_T3 && kind_q == `CCBS_ST_NMI_ACK) begin
      nmi_pend_d = 1'b0;
    end
    if (wr_acc) begin
      case (paddr)
        `CCBS_OFF_CTRL: ctrl_d = pwdata[4:0];
        `CCBS_OFF_FLAGS: begin
          flags_d = pwdata[3:0];
          cond_d = pwdata[7:4];
          if (pwdata[8]) begin
            flags_d[1] = !chain_s;
          end
        end
        `CCBS_OFF_SEG: seg_d = pwdata[6:0];
        default: ;
      endcase
    end
  end

  // interrupt code: nmi first, then trap, vectored, plain
  logic [3:0] irq_code;
  logic irq_any;
  always_comb begin
    irq_any = 1'b1;
    if (nmi_pend_q) begin
      irq_code = `CCBS_ST_NMI_ACK;
    end else if (!segf_s && ctrl_q[4]) begin
      irq_code = `CCBS_ST_SEG_TRAP_ACK;
    end else if (!virq_s && ctrl_q[2]) begin
      irq_code = `CCBS_ST_VECT_ACK;
    end else if (!pirq_s && ctrl_q[1]) begin
      irq_code = `CCBS_ST_PLAIN_ACK;
    end else begin
      irq_code = `CCBS_ST_INTERNAL;
      irq_any = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // block i/o step counter
  // ----------------------------------------------------------------
  always_comb begin
    blk_d = blk_q;
    count_d = count_q;
    rep_d = rep_q;
    blk_left_d = blk_left_q;
    blk_clks_d = blk_clks_q;
    case (blk_q)
      ccbs_pkg::CCBS_BLK_OFF: begin
        if (wr_acc && paddr == `CCBS_OFF_BLOCK && ctrl_q[0]) begin
          count_d = pwdata[15:0];
          rep_d = pwdata[16];
          blk_clks_d = 16'h0;
          blk_left_d = pwdata[16] ? `CCBS_BLK_REP_BASE_CLKS + `CCBS_BLK_REP_STEP_CLKS
            : `CCBS_BLK_SINGLE_CLKS;
          blk_d = ccbs_pkg::CCBS_BLK_STEP;
        end
      end
      ccbs_pkg::CCBS_BLK_STEP: begin
        blk_clks_d = blk_clks_q + 16'd1;
        blk_left_d = blk_left_q - 8'd1;
        if (blk_left_q == 8'd1) begin
          count_d = count_q - 16'd1;
          if (rep_q && count_q != 16'd1) begin
            blk_left_d = `CCBS_BLK_REP_STEP_CLKS;
          end else begin
            blk_d = ccbs_pkg::CCBS_BLK_DONE;
          end
        end
      end
      ccbs_pkg::CCBS_BLK_DONE: blk_d = ccbs_pkg::CCBS_BLK_OFF;
      default: blk_d = ccbs_pkg::CCBS_BLK_OFF;
    endcase
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ccbs_pkg::CCBS_IDLE;
      clk_cnt_q <= 4'h0;
      kind_q <= 4'h0;
      addr_q <= 16'h0;
      byte_q <= 1'b0;
      rd_q <= 1'b1;
      priv_q <= 1'b0;
      xlen_q <= 4'h0;
      rdata_q <= 16'h0;
      trap_q <= 1'b0;
      ctrl_q <= 5'h01;
      flags_q <= 4'h0;
      cond_q <= 4'h0;
      seg_q <= 7'h0;
      nmi_prev_q <= 1'b1;
      nmi_pend_q <= 1'b0;
      blk_q <= ccbs_pkg::CCBS_BLK_OFF;
      count_q <= 16'h0;
      rep_q <= 1'b0;
      blk_left_q <= 8'h0;
      blk_clks_q <= 16'h0;
    end else begin
      st_q <= st_d;
      clk_cnt_q <= clk_cnt_d;
      kind_q <= kind_d;
      addr_q <= addr_d;
      byte_q <= byte_d;
      rd_q <= rd_d;
      priv_q <= priv_d;
      xlen_q <= xlen_d;
      rdata_q <= rdata_d;
      trap_q <= trap_d;
      ctrl_q <= ctrl_d;
      flags_q <= flags_d;
      cond_q <= cond_d;
      seg_q <= seg_d;
      nmi_prev_q <= nmi_prev_d;
      nmi_pend_q <= nmi_pend_d;
      blk_q <= blk_d;
      count_q <= count_d;
      rep_q <= rep_d;
      blk_left_q <= blk_left_d;
      blk_clks_q <= blk_clks_d;
    end
  end

  // ----------------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------------
  logic busy, released;
  assign busy = st_q != ccbs_pkg::CCBS_IDLE && st_q != ccbs_pkg::CCBS_RELEASED;
  assign released = st_q == ccbs_pkg::CCBS_RELEASED;
  always_comb begin
    cycle_kind = busy ? kind_q : irq_any ? irq_code : `CCBS_ST_INTERNAL;
    // strobe low in t1 only; its rising edge marks a valid address
    addr_strobe_n = !(st_q == ccbs_pkg::CCBS_T1);
    addr_data_out = addr_q;
    addr_data_oe_n = !(st_q == ccbs_pkg::CCBS_T1 || (busy && !rd_q
      && st_q != ccbs_pkg::CCBS_T1));
    xfer_strobe_n = !(st_q == ccbs_pkg::CCBS_T2 || st_q == ccbs_pkg::CCBS_TW
      || st_q == ccbs_pkg::CCBS_T3) || !(is_mem || is_io);
    mem_access_n = !(busy && is_mem);
    byte_sel = byte_q;
    read_sel = rd_q;
    normal_mode = !ctrl_q[0];
    ctl_oe_n = released;
    bus_grant_n = !released;
    seg_num = ctrl_q[4] ? seg_q : 7'h0;
    chain_out_n = !ctrl_q[3];
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_never_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    cycle_kind != `CCBS_ST_RESERVED) else $error("reserved status driven");
  a_grant_after_release: assert property (@(posedge pclk) disable iff (!presetn)
    !bus_grant_n |-> $past(claim_s) == 1'b0)
    else $error("grant without claim");
  a_nmi_edge_pend: assert property (@(posedge pclk) disable iff (!presetn)
    (nmi_prev_q && !nmi_s) |=> nmi_pend_q) else $error("nmi edge lost");
  a_nmi_priority: assert property (@(posedge pclk) disable iff (!presetn)
    nmi_pend_q && !busy |-> cycle_kind == `CCBS_ST_NMI_ACK)
    else $error("nmi not first");
  a_wait_stretch: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == ccbs_pkg::CCBS_T2 && !wait_s && kind_q[3] |=> st_q == ccbs_pkg::CCBS_TW)
    else $error("wait ignored");
  a_mem_only: assert property (@(posedge pclk) disable iff (!presetn)
    !mem_access_n |-> kind_q[3] && busy) else $error("memory request on io");
  a_priv_trap: assert property (@(posedge pclk) disable iff (!presetn)
    start && claim_s && pwdata[22] && !ctrl_q[0] |=> trap_q && st_q == ccbs_pkg::CCBS_IDLE)
    else $error("privileged op ran");
  a_cycle_len: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == ccbs_pkg::CCBS_T1 |-> ##[2:9] st_q == ccbs_pkg::CCBS_T3)
    else $error("machine cycle length");
  a_single_21: assert property (@(posedge pclk) disable iff (!presetn)
    blk_q == ccbs_pkg::CCBS_BLK_OFF && blk_d == ccbs_pkg::CCBS_BLK_STEP && !pwdata[16]
    |-> ##22 blk_q == ccbs_pkg::CCBS_BLK_DONE) else $error("block step not 21");
  a_strobe_edge: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(addr_strobe_n) |-> !$past(addr_data_oe_n)) else $error("strobe without address");
  c_wait: cover property (@(posedge pclk) st_q == ccbs_pkg::CCBS_TW);
  c_grant: cover property (@(posedge pclk) !bus_grant_n);
  c_trap: cover property (@(posedge pclk) trap_q);
  c_block: cover property (@(posedge pclk) blk_q == ccbs_pkg::CCBS_BLK_DONE);
endmodule

// >>> hdl/ccbs_defs.svh
// Purpose: constants for the condition test and bus status block
// Assumes: 50 MHz pclk
// Notes: status codes, condition codes, cycle counts
`ifndef CCBS_DEFS_SVH
`define CCBS_DEFS_SVH
`define CCBS_CC_NEVER 4'h0
`define CCBS_CC_LT 4'h1
`define CCBS_CC_LE 4'h2
`define CCBS_CC_ULE 4'h3
`define CCBS_CC_OV 4'h4
`define CCBS_CC_MI 4'h5
`define CCBS_CC_Z 4'h6
`define CCBS_CC_C 4'h7
`define CCBS_CC_ALWAYS 4'h8
`define CCBS_CC_GE 4'h9
`define CCBS_CC_GT 4'ha
`define CCBS_CC_UGT 4'hb
`define CCBS_CC_NOV 4'hc
`define CCBS_CC_PL 4'hd
`define CCBS_CC_NZ 4'he
`define CCBS_CC_NC 4'hf
`define CCBS_ST_INTERNAL 4'h0
`define CCBS_ST_REFRESH 4'h1
`define CCBS_ST_IO 4'h2
`define CCBS_ST_SPECIAL_IO 4'h3
`define CCBS_ST_SEG_TRAP_ACK 4'h4
`define CCBS_ST_NMI_ACK 4'h5
`define CCBS_ST_PLAIN_ACK 4'h6
`define CCBS_ST_VECT_ACK 4'h7
`define CCBS_ST_DATA 4'h8
`define CCBS_ST_STACK 4'h9
`define CCBS_ST_EXT_DATA 4'ha
`define CCBS_ST_EXT_STACK 4'hb
`define CCBS_ST_PROG_NTH 4'hc
`define CCBS_ST_FETCH_FIRST 4'hd
`define CCBS_ST_EXT_XFER 4'he
`define CCBS_ST_RESERVED 4'hf
// block i/o and machine cycle timing in clocks
`define CCBS_BLK_SINGLE_CLKS 8'd21
`define CCBS_BLK_REP_BASE_CLKS 8'd11
`define CCBS_BLK_REP_STEP_CLKS 8'd10
`define CCBS_CYC_MIN_CLKS 4'd3
`define CCBS_CYC_MAX_CLKS 4'd10
// register offsets (apb byte addresses)
`define CCBS_OFF_CTRL 12'h000
`define CCBS_OFF_FLAGS 12'h004
`define CCBS_OFF_CYCLE 12'h008
`define CCBS_OFF_STATUS 12'h00c
`define CCBS_OFF_BLOCK 12'h010
`define CCBS_OFF_SEG 12'h014
`endif

// >>> hdl/ccbs_pkg.sv
// Purpose: shared types for the condition test and bus status block
// Assumes: used with ccbs_defs.svh
// Notes: nothing is imported
package ccbs_pkg;
  typedef enum logic [2:0] {
    CCBS_IDLE = 3'b000,
    CCBS_T1 = 3'b001,
    CCBS_T2 = 3'b010,
    CCBS_TW = 3'b011,
    CCBS_T3 = 3'b100,
    CCBS_TX = 3'b101,
    CCBS_RELEASED = 3'b110
  } ccbs_state_t;
  typedef enum logic [1:0] {
    CCBS_BLK_OFF = 2'b00,
    CCBS_BLK_STEP = 2'b01,
    CCBS_BLK_DONE = 2'b10
  } ccbs_blk_t;
endpackage

// >>> hdl/ccbs_cond_eval.sv
// Purpose: evaluate a 4-bit condition field against the flags
// Assumes: flags come from logic on pclk
// Notes: purely combinational
`timescale 1ns/100ps
`include "ccbs_defs.svh"
module ccbs_cond_eval (
  // condition and flags
  input wire logic [3:0] cond,
  input wire logic flag_c,
  input wire logic flag_z,
  input wire logic flag_s,
  input wire logic flag_pv,
  // result
  output logic cond_true
);
  logic sxv;
  always_comb begin
    sxv = flag_s ^ flag_pv;
    case (cond)
      `CCBS_CC_NEVER: cond_true = 1'b0;
      `CCBS_CC_ALWAYS: cond_true = 1'b1;
      `CCBS_CC_Z: cond_true = flag_z;
      `CCBS_CC_C: cond_true = flag_c;
      `CCBS_CC_MI: cond_true = flag_s;
      `CCBS_CC_OV: cond_true = flag_pv;
      `CCBS_CC_NZ: cond_true = !flag_z;
      `CCBS_CC_NC: cond_true = !flag_c;
      `CCBS_CC_PL: cond_true = !flag_s;
      `CCBS_CC_NOV: cond_true = !flag_pv;
      `CCBS_CC_GE: cond_true = !sxv;
      `CCBS_CC_LT: cond_true = sxv;
      `CCBS_CC_GT: cond_true = !(flag_z | sxv);
      `CCBS_CC_LE: cond_true = flag_z | sxv;
      `CCBS_CC_UGT: cond_true = !flag_c && !flag_z;
      `CCBS_CC_ULE: cond_true = flag_c | flag_z;
      default: cond_true = 1'b0;
    endcase
  end
endmodule

// >>> hdl/ccbs_sync.sv
// Purpose: two-flop synchroniser per bit
// Assumes: inputs from pins
// Notes: first stage is read only by the second
`timescale 1ns/100ps
module ccbs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q[i] <= INIT[i];
          s2_q[i] <= INIT[i];
        end else begin
          s1_q[i] <= din[i];
          s2_q[i] <= s1_q[i];
        end
      end
    end
  endgenerate
  assign dout = s2_q;
endmodule

// >>> verif/ccbs_mem_model.sv
// Purpose: memory and io device on the far side of the bus pins
// Assumes: with a hold count set the device idles not ready (wait low)
// Notes: data is inverted every cycle while not valid
`timescale 1ns/100ps
module ccbs_mem_model (
  // clock and bus pins
  input wire logic pclk,
  input wire logic addr_strobe_n,
  input wire logic xfer_strobe_n,
  input wire logic [15:0] addr_data_out,
  // behaviour and far side
  input wire logic [3:0] hold_cnt,
  output logic wait_n,
  output logic [15:0] addr_data_in
);
  logic [15:0] addr_q = 16'h0;
  logic [3:0] cnt_q = 4'h0;
  initial wait_n = 1'b1;
  initial addr_data_in = 16'h0;
  always @(posedge pclk) begin
    // not ready: hold wait low until the count is down to two
    if (addr_strobe_n == 1'b0) begin
      addr_q <= addr_data_out;
      cnt_q <= hold_cnt;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
    // ready goes up two clocks early to cover the block's pin synchroniser
    wait_n <= hold_cnt == 4'h0 || (!xfer_strobe_n && addr_strobe_n && cnt_q <= 4'h2);
    if (xfer_strobe_n == 1'b0 && cnt_q == 4'h0) begin
      addr_data_in <= addr_q ^ 16'h5a5a;
    end else begin
      addr_data_in <= ~addr_data_in;
    end
  end
endmodule

// >>> verif/test_ccbs_top.sv
// Purpose: self-checking bench for the condition and bus status block
// Assumes: apb master, zero-wait slave
// Notes: reads and t1 states are checked from queues of notes
`timescale 1ns/100ps
`include "ccbs_defs.svh"
module test_ccbs_top;
  typedef struct {logic [31:0] v; logic [31:0] m;} ccbs_note_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h2f07, fails = 0, n_tests = 0;
  logic [3:0] cycle_kind, hold_cnt = 4'h0;
  logic [6:0] seg_num;
  logic [15:0] addr_data_out, addr_data_in, a;
  logic addr_data_oe_n, addr_strobe_n, xfer_strobe_n, mem_access_n, byte_sel, read_sel;
  logic normal_mode, ctl_oe_n, wait_n, bus_grant_n, chain_out_n;
  logic bus_claim_n = 1'b1, nmi_n = 1'b1, test_chain_in = 1'b1, plain_irq_n = 1'b1;
  logic vect_irq_n = 1'b1, seg_fault_n = 1'b1;
  ccbs_note_t rd_q[$], nt;
  logic [31:0] ck_q[$];
  always #10 pclk = ~pclk;
  ccbs_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cycle_kind, .seg_num, .addr_data_out, .addr_data_oe_n, .addr_data_in,
    .addr_strobe_n, .xfer_strobe_n, .mem_access_n, .byte_sel, .read_sel, .normal_mode,
    .ctl_oe_n, .wait_n, .bus_claim_n, .bus_grant_n, .nmi_n, .plain_irq_n,
    .vect_irq_n, .seg_fault_n, .test_chain_in, .chain_out_n);
  ccbs_mem_model mem (.pclk, .addr_strobe_n, .xfer_strobe_n, .addr_data_out, .hold_cnt,
    .wait_n, .addr_data_in);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && n_tests != 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic apb_rd(input logic [11:0] ad, input logic [31:0] v, input logic [31:0] m);
    rd_q.push_back('{v, m});
    apb(1'b0, ad, 32'h0);
  endtask
  // one machine cycle; reads only, so the far side always answers
  task automatic run_cyc(input logic [3:0] kind, input logic bsel, input logic [3:0] hold);
    logic [3:0] k;
    a = $random(seed);
    k = (kind == 4'hf) ? 4'h0 : kind;
    ck_q.push_back({9'h0, k, !(k >= 4'h8 && k <= 4'hd), bsel, 1'b1, a});
    hold_cnt <= hold;
    apb(1'b1, `CCBS_OFF_CYCLE, {10'h0, 1'b1, bsel, kind, a});
    repeat (24) @(posedge pclk);
  endtask
  function automatic logic cond_ref(input logic [3:0] cc, input logic [3:0] f);
    logic c, z, s, v, r;
    {c, z, s, v} = f;
    case (cc[2:0])
      3'h0: r = 1'b0;
      3'h1: r = s ^ v;
      3'h2: r = z | (s ^ v);
      3'h3: r = c | z;
      3'h4: r = v;
      3'h5: r = s;
      3'h6: r = z;
      default: r = c;
    endcase
    return cc[3] ? !r : r;
  endfunction
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      nt = (rd_q.size() != 0) ? rd_q.pop_front() : '{32'hdead, 32'hffffffff};
      chk(prdata & nt.m, nt.v);
    end
    if (addr_strobe_n === 1'b0) begin
      chk({9'h0, cycle_kind, mem_access_n, byte_sel, read_sel, addr_data_out},
        (ck_q.size() != 0) ? ck_q.pop_front() : 32'hffffffff);
    end
  end
  initial begin
    #200000;
    fails = fails + 1;
    wrap_up();
  end
  initial begin
    logic [3:0] f;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({31'h0, normal_mode}, 32'h0);
    for (int i = 0; i < 32; i++) begin
      f = $random(seed);
      apb(1'b1, `CCBS_OFF_FLAGS, {24'h0, i[3:0], f});
      apb_rd(`CCBS_OFF_FLAGS, {23'h0, cond_ref(i[3:0], f), i[3:0], f}, 32'h1ff);
    end
    for (int i = 0; i < 2; i++) begin
      test_chain_in <= i[0];
      repeat (4) @(posedge pclk);
      apb(1'b1, `CCBS_OFF_FLAGS, 32'h100);
      apb_rd(`CCBS_OFF_FLAGS, {30'h0, !i[0], 1'b0}, 32'h2);
    end
    nmi_n <= 1'b0;
    repeat (4) @(posedge pclk);
    apb_rd(`CCBS_OFF_SEG, 32'h100, 32'h100);
    nmi_n <= 1'b1;
    for (int k = 1; k < 16; k++) run_cyc(k[3:0], k[0], 4'h0);
    apb_rd(`CCBS_OFF_SEG, 32'h0, 32'h100);
    run_cyc(4'h2, 1'b0, 4'h5);
    apb_rd(`CCBS_OFF_STATUS, {16'h0, a ^ 16'h5a5a}, 32'hffff);
    apb(1'b1, `CCBS_OFF_CTRL, 32'h17);
    plain_irq_n <= 1'b0;
    repeat (4) @(posedge pclk);
    chk({28'h0, cycle_kind}, {28'h0, `CCBS_ST_PLAIN_ACK});
    vect_irq_n <= 1'b0;
    repeat (4) @(posedge pclk);
    chk({28'h0, cycle_kind}, {28'h0, `CCBS_ST_VECT_ACK});
    seg_fault_n <= 1'b0;
    repeat (4) @(posedge pclk);
    chk({28'h0, cycle_kind}, {28'h0, `CCBS_ST_SEG_TRAP_ACK});
    apb_rd(`CCBS_OFF_SEG, 32'he0, 32'he0);
    {plain_irq_n, vect_irq_n, seg_fault_n} <= 3'h7;
    apb(1'b1, `CCBS_OFF_CTRL, 32'h1);
    apb(1'b1, `CCBS_OFF_BLOCK, 32'h1_0003);
    repeat (80) @(posedge pclk);
    apb_rd(`CCBS_OFF_BLOCK, {16'd41, 16'd0}, 32'hffffffff);
    apb(1'b1, `CCBS_OFF_BLOCK, 32'h3);
    repeat (40) @(posedge pclk);
    apb_rd(`CCBS_OFF_BLOCK, {16'd21, 16'd2}, 32'hffffffff);
    apb(1'b1, `CCBS_OFF_CTRL, 32'h11);
    apb(1'b1, `CCBS_OFF_SEG, 32'h5b);
    @(posedge pclk);
    chk({25'h0, seg_num}, 32'h5b);
    apb(1'b1, `CCBS_OFF_CTRL, 32'h0);
    @(posedge pclk);
    chk({31'h0, normal_mode}, 32'h1);
    apb(1'b1, `CCBS_OFF_CYCLE, 32'h2_1234);
    repeat (24) @(posedge pclk);
    apb_rd(`CCBS_OFF_SEG, 32'h200, 32'h200);
    apb(1'b1, `CCBS_OFF_CTRL, 32'h1);
    bus_claim_n <= 1'b0;
    for (int i = 0; i < 20 && bus_grant_n !== 1'b0; i++) @(posedge pclk);
    chk({30'h0, ctl_oe_n, bus_grant_n}, 32'h2);
    bus_claim_n <= 1'b1;
    repeat (8) @(posedge pclk);
    chk({31'h0, bus_grant_n}, 32'h1);
    apb_rd(12'h0f0, 32'h0, 32'hffffffff);
    repeat (2) @(posedge pclk);
    wrap_up();
  end
endmodule
